// ==== ioch_defs.svh ====
// offsets, field positions and timing counts of the i/o channel
`ifndef IOCH_DEFS_SVH
`define IOCH_DEFS_SVH
`define IOCH_A_OCW     3'h0
`define IOCH_A_OCW_OVR 3'h1
`define IOCH_A_ODW     3'h2
`define IOCH_A_OAW     3'h3
`define IOCH_A_CFG     3'h4
`define IOCH_A_IDW     3'h0
`define IOCH_A_ISW     3'h1
`define IOCH_BLK_BIT   23
`define IOCH_DIR_BIT   22
`define IOCH_CFG_INTEG 16
`define IOCH_CFG_DUAL  17
`define IOCH_CFG_XSEQ  18
`define IOCH_STAT_OK   2'h2
`define IOCH_CLK_NS    10
`define IOCH_SLOT_NS   200
`define IOCH_TMO_NS    2000
`define IOCH_SLOT_CYC  ((`IOCH_SLOT_NS + `IOCH_CLK_NS - 1) / `IOCH_CLK_NS)
`define IOCH_TMO_CYC   (`IOCH_TMO_NS / `IOCH_CLK_NS)
`endif

// ==== ioch_pkg.sv ====
// types shared by the i/o channel design
package ioch_pkg;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_out  = 3'b001,
      st_mreq = 3'b011,
      st_bout = 3'b010,
      st_send = 3'b110,
      st_xout = 3'b111
   } ioch_st_t;
   typedef enum logic [1:0] {
      k_cmd  = 2'h0,
      k_data = 2'h1,
      k_addr = 2'h2,
      k_wc   = 2'h3
   } ioch_kind_t;
   typedef struct packed {
      logic        accepted;
      logic        data_avail;
      logic        xfer_req;
      logic        unit_ready;
      logic        dir_in;
      logic [19:0] unit_addr;
      logic [23:0] in_data;
      logic [23:0] status;
   } ioch_uin_t;
   typedef struct packed {
      ioch_st_t    st;
      ioch_kind_t  kind;
      logic        busy;
      logic        blk;
      logic        bin;
      logic        integ;
      logic        dual;
      logic        xseq;
      logic        xs;
      logic        half;
      logic        aw_done;
      logic        ready;
      logic [23:0] rdata;
      logic [23:0] out_word;
      logic        cmd_here;
      logic        data_here;
      logic        addr_here;
      logic        wc_here;
      logic        data_acc;
      logic        pend_acc;
      logic        send;
      logic        mem_req;
      logic        mem_we;
      logic [19:0] mem_addr;
      logic [47:0] mem_wdata;
      logic [19:0] xfer_addr;
      logic [15:0] word_cnt;
      logic        slot;
      logic [7:0]  slot_cnt;
      logic [7:0]  tmo;
      logic [1:0]  stat_cnt;
      logic        acc_q;
      logic        dav_q;
   } ioch_ch_t;
endpackage

// ==== ioch_prio.sv ====
// memory-cycle priority matrix cell for one channel level
`timescale 1ns/1ps
module ioch_prio
   import ioch_pkg::*;
(
   input  wire logic clk,
   input  wire logic rstn,
   input  wire logic req,
   input  wire logic hi_req,
   input  wire logic grant_in,
   input  wire logic err_corr,
   output logic      granted,
   output logic      lo_inhibit
);
   logic next_inhibit;

   always_comb begin
      granted      = req & ~hi_req & grant_in & ~err_corr;
      next_inhibit = req | hi_req;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         lo_inhibit <= 1'b0;
      end else begin
         lo_inhibit <= next_inhibit;
      end
   end
endmodule

// ==== ioch_channel.sv ====
// i/o channel: cpu port, unit handshakes, block memory moves
//
// The address-and-strobe port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "ioch_defs.svh"

// What this block does
// - highest requesting channel hides the memory grant from lower ones
// - busy channel refuses outputs except a command with override
// - single output loads buffer, raises its strobe, sets busy
// - unit acceptance clears busy for the next transfer
// - block output requests cycles, fetches, strobes, repeats per accept
// - data input only when data available; then word passed, accepted
// - block input captures word, accepts it, requests a store cycle
// - further store requests ignored until the write cycle ends
// - ready only when executable; override command is executed even while busy and restarts the output
// - command or data strobe answered by accept, both then released
// - status input completes with no unit handshake
// - address and word count outputs raise their own strobes
// - free channel answers a transfer request with send
// - unit input: capture word, busy, request memory write
// - unit output: memory read, then one pulse of data here
// - integral mode sends commands without handshake
// - dual mode: alternating scan slots, extended until handshake or timeout
// - dual mode input needs two recent slots; accept in next own slot
// - dual block mode pairs two 24-bit words per memory cycle
// - memory request granted unless cpu is in an error-correct cycle or a higher channel requests
module ioch_channel
   import ioch_pkg::*;
#(
   parameter int CHAN_ID  = 0,
   parameter int SLOT_CYC = `IOCH_SLOT_CYC,
   parameter int TMO_CYC  = `IOCH_TMO_CYC
)(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic [2:0]  cpu_addr,
   input  wire logic [23:0] cpu_wdata,
   input  wire logic        cpu_wr,
   input  wire logic        cpu_rd,
   output logic      [23:0] cpu_rdata,
   output logic             cpu_ready,
   output logic             chan_busy,
   output logic      [23:0] unit_word,
   output logic             cmd_here,
   output logic             data_here,
   output logic             addr_here,
   output logic             wc_here,
   output logic             data_acc,
   output logic             send,
   input  wire logic        unit_accepted,
   input  wire logic        unit_data_avail,
   input  wire logic        unit_xfer_req,
   input  wire logic        unit_ready,
   input  wire logic        unit_dir_in,
   input  wire logic [19:0] unit_addr,
   input  wire logic [23:0] unit_in_data,
   input  wire logic [23:0] unit_status,
   output logic             mem_req,
   output logic             mem_we,
   output logic      [19:0] mem_addr,
   output logic      [47:0] mem_wdata,
   input  wire logic [47:0] mem_rdata,
   input  wire logic        mem_grant,
   input  wire logic        cpu_err_correct,
   input  wire logic        hi_req_in,
   output logic             lo_inhibit_out
);
   localparam logic [7:0] SLOT_M1 = 8'(SLOT_CYC - 1);
   localparam logic [7:0] TMO_M1  = 8'(TMO_CYC - 1);
   localparam logic       OWN_ID  = 1'(CHAN_ID);

   ioch_uin_t                    u_raw;
   ioch_uin_t                    u;
   ioch_uin_t                    next_u;
   logic [$bits(ioch_uin_t)-1:0] s1;
   logic [$bits(ioch_uin_t)-1:0] s2;
   logic [$bits(ioch_uin_t)-1:0] s3;
   ioch_ch_t                     ch;
   ioch_ch_t                     n;
   logic                         own;
   logic                         acc_rise;
   logic                         dav_rise;
   logic                         ostb;
   logic                         hold;
   logic                         slot_end;
   logic                         start_own;
   logic                         ovr;
   logic                         ok;
   logic                         last;
   logic                         stat_ok;
   logic                         grant;
   logic [19:0]                  step;
   logic [19:0]                  ntar;

   assign u_raw = '{accepted: unit_accepted, data_avail: unit_data_avail,
                    xfer_req: unit_xfer_req, unit_ready: unit_ready,
                    dir_in: unit_dir_in, unit_addr: unit_addr,
                    in_data: unit_in_data, status: unit_status};

   // three-stage pin sync, bit changes once stages two and three agree
   always_comb begin
      next_u = ioch_uin_t'((s2 & s3) | (u & (s2 | s3)));
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
         u  <= '0;
      end else begin
         s1 <= u_raw;
         s2 <= s1;
         s3 <= s2;
         u  <= next_u;
      end
   end

   ioch_prio u_prio (
      .clk        (clk),
      .rstn       (rstn),
      .req        (ch.mem_req),
      .hi_req     (hi_req_in),
      .grant_in   (mem_grant),
      .err_corr   (cpu_err_correct),
      .granted    (grant),
      .lo_inhibit (lo_inhibit_out)
   );

   always_comb begin
      n         = ch;
      n.ready   = 1'b0;
      n.acc_q   = u.accepted;
      n.dav_q   = u.data_avail;
      own       = ~ch.dual | (ch.slot == OWN_ID);
      acc_rise  = u.accepted & ~ch.acc_q;
      dav_rise  = u.data_avail & ~ch.dav_q;
      ostb      = ch.cmd_here | ch.data_here | ch.addr_here | ch.wc_here;
      slot_end  = ch.slot_cnt == SLOT_M1;
      hold      = ch.dual & own & (ostb | ch.data_acc) & (ch.tmo != TMO_M1);
      start_own = ch.dual & slot_end & ~hold & (ch.slot != OWN_ID);
      ovr       = cpu_wr & (cpu_addr == `IOCH_A_OCW_OVR);
      ok        = ~ch.busy | ovr;
      last      = ch.word_cnt <= 16'h0001;
      stat_ok   = ~ch.dual | (ch.stat_cnt == `IOCH_STAT_OK);
      step      = ch.dual ? 20'h00002 : 20'h00001;
      ntar      = ch.xfer_addr + step;
      // scan slot timing
      if (!slot_end) begin
         n.slot_cnt = ch.slot_cnt + 8'h01;
      end else if (hold) begin
         n.tmo = ch.tmo + 8'h01;
      end else begin
         n.slot_cnt = 8'h00;
         n.tmo      = 8'h00;
         n.slot     = ~ch.slot;
      end
      if (!ch.dual) begin
         n.stat_cnt = 2'h0;
      end else if (start_own && ch.stat_cnt != `IOCH_STAT_OK) begin
         n.stat_cnt = ch.stat_cnt + 2'h1;
      end
      if (start_own && ch.pend_acc) begin
         n.pend_acc = 1'b0;
         n.data_acc = 1'b1;
      end
      if (ch.data_acc && !u.data_avail) begin
         n.data_acc = 1'b0;
      end
      unique case (ch.st)
         st_idle: begin
            if (ch.blk && ch.bin && own && dav_rise) begin
               n.data_acc = 1'b1;
               if (ch.dual && !ch.half) begin
                  n.half             = 1'b1;
                  n.mem_wdata[47:24] = u.in_data;
               end else begin
                  n.half            = 1'b0;
                  n.mem_wdata[23:0] = u.in_data;
                  if (!ch.dual) begin
                     n.mem_wdata[47:24] = 24'h000000;
                  end
                  n.mem_req  = 1'b1;
                  n.mem_we   = 1'b1;
                  n.mem_addr = ch.xfer_addr;
                  n.st       = st_mreq;
               end
            end else if (ch.xseq && !ch.busy && u.xfer_req && !hi_req_in &&
                         !cpu_wr && !cpu_rd) begin
               n.send = 1'b1;
               n.busy = 1'b1;
               n.st   = st_send;
            end
         end
         st_out: begin
            if (own && !ostb) begin
               n.cmd_here  = ch.kind == k_cmd;
               n.data_here = ch.kind == k_data;
               n.addr_here = ch.kind == k_addr;
               n.wc_here   = ch.kind == k_wc;
            end else if (own && acc_rise) begin
               n.cmd_here  = 1'b0;
               n.data_here = 1'b0;
               n.addr_here = 1'b0;
               n.wc_here   = 1'b0;
               n.busy      = ch.blk;
               n.st        = st_idle;
               if (ch.blk && !ch.bin) begin
                  n.mem_req  = 1'b1;
                  n.mem_we   = 1'b0;
                  n.mem_addr = ch.xfer_addr;
                  n.st       = st_mreq;
               end
            end
         end
         st_mreq: begin
            if (grant) begin
               n.mem_req = 1'b0;
               if (ch.xs) begin
                  n.xs = 1'b0;
                  if (ch.mem_we) begin
                     n.busy = 1'b0;
                     n.st   = st_idle;
                  end else begin
                     n.out_word  = mem_rdata[23:0];
                     n.data_here = 1'b1;
                     n.st        = st_xout;
                  end
               end else if (ch.mem_we) begin
                  n.xfer_addr = ntar;
                  n.word_cnt  = ch.word_cnt - 16'h0001;
                  n.st        = st_idle;
                  if (last) begin
                     n.blk  = 1'b0;
                     n.busy = 1'b0;
                  end
               end else begin
                  n.mem_wdata = mem_rdata;
                  n.out_word  = ch.dual ? mem_rdata[47:24] : mem_rdata[23:0];
                  n.half      = 1'b0;
                  n.st        = st_bout;
               end
            end
         end
         st_bout: begin
            if (own && !ch.data_here) begin
               n.data_here = 1'b1;
            end else if (own && acc_rise) begin
               n.data_here = 1'b0;
               if (ch.dual && !ch.half) begin
                  n.half     = 1'b1;
                  n.out_word = ch.mem_wdata[23:0];
               end else begin
                  n.xfer_addr = ntar;
                  n.word_cnt  = ch.word_cnt - 16'h0001;
                  if (last) begin
                     n.blk  = 1'b0;
                     n.busy = 1'b0;
                     n.st   = st_idle;
                  end else begin
                     n.mem_req  = 1'b1;
                     n.mem_we   = 1'b0;
                     n.mem_addr = ntar;
                     n.st       = st_mreq;
                  end
               end
            end
         end
         st_send: begin
            if (u.unit_ready) begin
               n.send      = 1'b0;
               n.xs        = 1'b1;
               n.mem_req   = 1'b1;
               n.mem_we    = u.dir_in;
               n.mem_addr  = u.unit_addr;
               n.mem_wdata = {24'h000000, u.in_data};
               n.st        = st_mreq;
            end
         end
         st_xout: begin
            n.data_here = 1'b0;
            n.busy      = 1'b0;
            n.st        = st_idle;
         end
         default: begin
            n.st = st_idle;
         end
      endcase
      // cpu instructions, override aborts whatever runs
      if (cpu_wr && ok) begin
         if (ovr) begin
            n.busy      = 1'b0;
            n.blk       = 1'b0;
            n.st        = st_idle;
            n.cmd_here  = 1'b0;
            n.data_here = 1'b0;
            n.addr_here = 1'b0;
            n.wc_here   = 1'b0;
            n.send      = 1'b0;
            n.mem_req   = 1'b0;
            n.xs        = 1'b0;
         end
         n.ready = 1'b1;
         n.half  = 1'b0;
         unique case (cpu_addr)
            `IOCH_A_OCW, `IOCH_A_OCW_OVR: begin
               n.out_word = cpu_wdata;
               n.kind     = k_cmd;
               if (!ch.xseq) begin
                  n.blk = cpu_wdata[`IOCH_BLK_BIT];
                  n.bin = cpu_wdata[`IOCH_DIR_BIT];
               end
               if (ch.integ) begin
                  n.busy = n.blk;
                  if (n.blk && !n.bin) begin
                     n.mem_req  = 1'b1;
                     n.mem_we   = 1'b0;
                     n.mem_addr = ch.xfer_addr;
                     n.busy     = 1'b1;
                     n.st       = st_mreq;
                  end
               end else begin
                  n.busy = 1'b1;
                  n.st   = st_out;
               end
            end
            `IOCH_A_ODW: begin
               n.out_word = cpu_wdata;
               n.kind     = (ch.xseq && ch.aw_done) ? k_wc : k_data;
               n.aw_done  = 1'b0;
               n.busy     = 1'b1;
               n.st       = st_out;
            end
            `IOCH_A_OAW: begin
               n.xfer_addr = cpu_wdata[19:0];
               if (ch.xseq) begin
                  n.out_word = cpu_wdata;
                  n.kind     = k_addr;
                  n.aw_done  = 1'b1;
                  n.busy     = 1'b1;
                  n.st       = st_out;
               end
            end
            `IOCH_A_CFG: begin
               n.word_cnt = cpu_wdata[15:0];
               n.integ    = cpu_wdata[`IOCH_CFG_INTEG];
               n.dual     = cpu_wdata[`IOCH_CFG_DUAL];
               n.xseq     = cpu_wdata[`IOCH_CFG_XSEQ];
            end
            default: begin
               n.ready = 1'b0;
            end
         endcase
      end
      if (cpu_rd) begin
         n.rdata = 24'h000000;
         unique case (cpu_addr)
            `IOCH_A_IDW: begin
               if (!ch.busy && !ch.blk && u.data_avail && !ch.data_acc &&
                   !ch.pend_acc && stat_ok) begin
                  n.rdata = u.in_data;
                  n.ready = 1'b1;
                  if (ch.dual) begin
                     n.pend_acc = 1'b1;
                  end else begin
                     n.data_acc = 1'b1;
                  end
               end
            end
            `IOCH_A_ISW: begin
               if (stat_ok) begin
                  n.rdata = u.status;
                  n.ready = 1'b1;
               end
            end
            `IOCH_A_CFG: begin
               n.rdata = {ch.busy, ch.blk, ch.bin, ch.integ, ch.dual,
                          ch.xseq, ch.stat_cnt, ch.word_cnt};
               n.ready = 1'b1;
            end
            default: begin
               n.rdata = 24'h000000;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         ch <= '0;
      end else begin
         ch <= n;
      end
   end

   assign cpu_rdata = ch.rdata;
   assign cpu_ready = ch.ready;
   assign chan_busy = ch.busy;
   assign unit_word = ch.out_word;
   assign cmd_here  = ch.cmd_here;
   assign data_here = ch.data_here;
   assign addr_here = ch.addr_here;
   assign wc_here   = ch.wc_here;
   assign data_acc  = ch.data_acc;
   assign send      = ch.send;
   assign mem_req   = ch.mem_req;
   assign mem_we    = ch.mem_we;
   assign mem_addr  = ch.mem_addr;
   assign mem_wdata = ch.mem_wdata;

   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   property p_refuse_busy;
      cpu_wr && cpu_addr == `IOCH_A_ODW && ch.busy |=> !ch.ready;
   endproperty
   a_refuse_busy: assert property (p_refuse_busy)
      else $error("output taken while busy");

   property p_out_start;
      cpu_wr && cpu_addr == `IOCH_A_ODW && !ch.busy && !ch.dual
      |=> ch.busy && ch.st == st_out ##1 (ch.data_here || ch.wc_here);
   endproperty
   a_out_start: assert property (p_out_start)
      else $error("output strobe not raised");

   property p_accept;
      ch.st == st_out && ostb && own && acc_rise && !ch.blk && !cpu_wr
      |=> !ch.busy && !ch.cmd_here && !ch.data_here;
   endproperty
   a_accept: assert property (p_accept)
      else $error("accept did not clear busy");

   property p_status;
      cpu_rd && cpu_addr == `IOCH_A_ISW && !ch.dual
      |=> ch.ready && ch.rdata == $past(u.status);
   endproperty
   a_status: assert property (p_status)
      else $error("status input not immediate");

   property p_idw;
      cpu_rd && cpu_addr == `IOCH_A_IDW && !ch.busy && !ch.blk &&
      !ch.dual && u.data_avail && !ch.data_acc && !ch.pend_acc
      |=> ch.ready && ch.data_acc;
   endproperty
   a_idw: assert property (p_idw)
      else $error("data input not accepted");

   property p_store_hold;
      ch.st == st_mreq && ch.mem_we && !grant && !cpu_wr
      |=> $stable(ch.mem_wdata) && ch.mem_req;
   endproperty
   a_store_hold: assert property (p_store_hold)
      else $error("store word changed during write");

   property p_grant;
      cpu_err_correct || hi_req_in |-> !grant;
   endproperty
   a_grant: assert property (p_grant)
      else $error("grant seen while blocked");

   property p_send;
      ch.st == st_idle && ch.xseq && !ch.busy && u.xfer_req &&
      !hi_req_in && !cpu_wr && !cpu_rd && !(ch.blk && ch.bin)
      |=> ch.send ##1 (ch.send || ch.mem_req);
   endproperty
   a_send: assert property (p_send)
      else $error("send not raised");

   sequence s_xgrant;
      ch.st == st_mreq && ch.xs && !ch.mem_we && grant && !cpu_wr;
   endsequence
   sequence s_xpulse;
      ch.data_here && ch.busy ##1 !ch.data_here && !ch.busy;
   endsequence
   property p_xout;
      s_xgrant |=> s_xpulse;
   endproperty
   a_xout: assert property (p_xout)
      else $error("data here not a single pulse");

   property p_slot;
      ch.dual && slot_end && !hold |=> ch.slot != $past(ch.slot);
   endproperty
   a_slot: assert property (p_slot)
      else $error("scan slot did not alternate");
endmodule

// ==== ioch_unit_model.sv ====
// unit controller model on the far side of the channel
`timescale 1ns/1ps
module ioch_unit (
   input  wire logic        clk,
   input  wire logic        strobe,
   input  wire logic        data_acc,
   input  wire logic [3:0]  lag,
   input  wire logic [23:0] word_in,
   output logic             accepted = 1'b0,
   output logic             data_avail = 1'b0,
   output logic      [23:0] in_data,
   output logic      [23:0] status,
   output logic      [23:0] got = 24'h0
);
   logic [3:0] cnt = 4'h0;
   // status always on line
   assign status  = 24'h00c3a5;
   // idle data lines show the inverse word
   assign in_data = data_avail ? 24'h5a0f3c : 24'ha5f0c3;
   always @(posedge clk) begin
      if (!strobe) begin
         cnt      <= 4'h0;
         accepted <= 1'b0;
      end else if (cnt == lag) begin
         accepted <= 1'b1;
         got      <= word_in;
      end else begin
         cnt <= cnt + 4'h1;
      end
      if (data_acc) begin
         data_avail <= 1'b0;
      end else begin
         data_avail <= 1'b1;
      end
   end
endmodule

// ==== tb_top.sv ====
// self-checking bench for the i/o channel
`timescale 1ns/1ps
module tb_top;
   logic        clk, rstn, cpu_wr, cpu_rd, cpu_ready, chan_busy, send;
   logic        cmd_here, data_here, addr_here, wc_here, data_acc;
   logic        accepted, data_avail, mem_req, mem_we, mem_grant;
   logic        err_corr, hi_req, lo_inh;
   logic        xreq, xrdy, xin;
   logic [2:0]  cpu_addr;
   logic [3:0]  lag;
   logic [19:0] mem_addr, xaddr;
   logic [23:0] cpu_wdata, cpu_rdata, unit_word, in_data, status, got;
   logic [47:0] mem_wdata, mem_rdata;
   logic [52:0] rows [5];
   int          miscompares, samples_checked;

   ioch_channel u_dut (
      .clk(clk), .rstn(rstn), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
      .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
      .cpu_ready(cpu_ready), .chan_busy(chan_busy), .unit_word(unit_word),
      .cmd_here(cmd_here), .data_here(data_here), .addr_here(addr_here),
      .wc_here(wc_here), .data_acc(data_acc), .send(send),
      .unit_accepted(accepted), .unit_data_avail(data_avail),
      .unit_xfer_req(xreq), .unit_ready(xrdy), .unit_dir_in(xin),
      .unit_addr(xaddr), .unit_in_data(in_data), .unit_status(status),
      .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_grant(mem_grant),
      .cpu_err_correct(err_corr), .hi_req_in(hi_req),
      .lo_inhibit_out(lo_inh));

   ioch_unit u_unit (
      .clk(clk), .strobe(cmd_here | data_here | addr_here | wc_here),
      .data_acc(data_acc), .lag(lag), .word_in(unit_word),
      .accepted(accepted), .data_avail(data_avail), .in_data(in_data),
      .status(status), .got(got));

   always #5 clk = ~clk;

   task automatic chk(input string n, input logic [47:0] s, e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cpu(input logic [2:0] a, input logic [23:0] d,
                      input logic rd);
      @(posedge clk);
      cpu_addr  <= a;
      cpu_wdata <= d;
      cpu_rd    <= rd;
      cpu_wr    <= !rd;
      @(posedge clk);
      cpu_rd <= 1'b0;
      cpu_wr <= 1'b0;
      #1;
   endtask

   // idle: wait for busy low, else wait for a memory request
   task automatic wait_for(input logic idle);
      #1;
      for (int i = 0; i < 80; i++) begin
         if (idle ? chan_busy === 1'b0 : mem_req === 1'b1)
            break;
         @(posedge clk);
         #1;
      end
   endtask

   // unit-sequenced transfer: request, ready, memory cycle
   task automatic xfer(input logic din);
      @(posedge clk);
      xin  <= din;
      xreq <= 1'b1;
      wait (send === 1'b1);
      @(posedge clk);
      xreq <= 1'b0;
      xrdy <= 1'b1;
      wait_for(1'b0);
      chk("xaddr", mem_addr, 48'h333);
      chk("xwe", mem_we, 48'(din));
      chk("xbusy", chan_busy, 48'h1);
      if (din)
         chk("xin", mem_wdata, 48'h5a0f3c);
      @(posedge clk);
      xrdy      <= 1'b0;
      mem_grant <= 1'b1;
      @(posedge clk);
      mem_grant <= 1'b0;
      #1;
      chk("xpulse", data_here, 48'(!din));
      if (!din)
         chk("xout", unit_word, 48'h654321);
      wait_for(1'b1);
      chk("xend", data_here, 48'h0);
   endtask

   initial begin
      logic        rd, er;
      logic [2:0]  a;
      logic [23:0] d, ed;
      {clk, rstn, cpu_wr, cpu_rd, mem_grant, err_corr, hi_req} = '0;
      {cpu_addr, cpu_wdata, mem_rdata, xreq, xrdy, xin} = '0;
      xaddr = 20'h00333;
      lag = 4'h2;
      rows = '{{1'b0, 3'h0, 24'h000011, 1'b1, 24'h0},
               {1'b0, 3'h2, 24'h123456, 1'b1, 24'h0},
               {1'b1, 3'h1, 24'h0, 1'b1, 24'h00c3a5},
               {1'b1, 3'h0, 24'h0, 1'b1, 24'h5a0f3c},
               {1'b1, 3'h7, 24'h0, 1'b0, 24'h0}};
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         {rd, a, d, er, ed} = rows[i];
         cpu(a, d, rd);
         chk("ready", cpu_ready, er);
         if (rd) begin
            chk("rdata", cpu_rdata, ed);
            if (a == 3'h0)
               chk("acc", data_acc, 48'h1);
         end else begin
            chk("word", unit_word, d);
            chk("busy", chan_busy, 48'h1);
            wait_for(1'b1);
            chk("got", got, d);
         end
         $display("test row %0d done", i);
      end
      lag <= 4'h8;
      cpu(3'h2, 24'h0000aa, 1'b0);
      cpu(3'h2, 24'h0000bb, 1'b0);
      chk("refused", cpu_ready, 48'h0);
      chk("kept", unit_word, 48'h0000aa);
      cpu(3'h1, 24'h0000cc, 1'b0);
      chk("override", cpu_ready, 48'h1);
      wait_for(1'b1);
      chk("got", got, 48'h0000cc);
      $display("test override done");
      lag <= 4'h1;
      cpu(3'h4, 24'h000002, 1'b0);
      cpu(3'h3, 24'h000100, 1'b0);
      cpu(3'h0, 24'h800000, 1'b0);
      wait_for(1'b0);
      chk("addr", mem_addr, 48'h100);
      chk("we", mem_we, 48'h0);
      mem_grant <= 1'b1;
      hi_req    <= 1'b1;
      mem_rdata <= 48'habcdef;
      repeat (3) @(posedge clk);
      #1;
      chk("hidden", mem_req, 48'h1);
      chk("inhibit", lo_inh, 48'h1);
      @(posedge clk);
      hi_req   <= 1'b0;
      err_corr <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("ecc", mem_req, 48'h1);
      @(posedge clk);
      err_corr <= 1'b0;
      @(posedge clk);
      mem_grant <= 1'b0;
      mem_rdata <= 48'h654321;
      wait_for(1'b0);
      chk("got", got, 48'habcdef);
      chk("next", mem_addr, 48'h101);
      @(posedge clk);
      mem_grant <= 1'b1;
      @(posedge clk);
      mem_grant <= 1'b0;
      wait_for(1'b1);
      chk("last", got, 48'h654321);
      $display("test block output done");
      cpu(3'h4, 24'h040000, 1'b0);
      cpu(3'h3, 24'h000222, 1'b0);
      @(posedge clk);
      #1;
      chk("ahere", addr_here, 48'h1);
      wait_for(1'b1);
      chk("got", got, 48'h222);
      cpu(3'h2, 24'h000005, 1'b0);
      @(posedge clk);
      #1;
      chk("wchere", wc_here, 48'h1);
      wait_for(1'b1);
      chk("got", got, 48'h5);
      xfer(1'b1);
      xfer(1'b0);
      $display("test unit sequenced done");
      cpu(3'h4, 24'h020000, 1'b0);
      cpu(3'h1, 24'h0, 1'b1);
      chk("stat wait", cpu_ready, 48'h0);
      repeat (100) @(posedge clk);
      cpu(3'h1, 24'h0, 1'b1);
      chk("stat ready", cpu_ready, 48'h1);
      chk("stat", cpu_rdata, 48'hc3a5);
      $display("test dual scan done");
      cpu(3'h2, 24'h0000dd, 1'b0);
      chk("busy", chan_busy, 48'h1);
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      rstn <= 1'b1;
      #1;
      chk("rst busy", chan_busy, 48'h0);
      chk("rst word", unit_word, 48'h0);
      cpu(3'h4, 24'h0, 1'b1);
      chk("rst ready", cpu_ready, 48'h1);
      chk("rst cfg", cpu_rdata, 48'h0);
      $display("test reset done");
      close_out();
   end

   // watchdog at several times the expected run
   initial begin
      #40000;
      miscompares++;
      close_out();
   end
endmodule
